//--- common/bpc_pkg.sv
// package for the bidirectional port block: register map, reset values, carriers
package bpc_pkg;
  localparam int          DATA_W         = 8;
  localparam logic [11:0] ADDR_DATA      = 12'h01c; // index 07h times four
  localparam logic [11:0] ADDR_DIRECTION = 12'h21c; // index 87h times four
  localparam logic [7:0]  IDX_DATA       = 8'h07;
  localparam logic [7:0]  IDX_DIRECTION  = 8'h87;
  localparam logic [7:0]  DIR_RESET      = 8'hff;
  localparam logic [7:0]  LATCH_INIT     = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // pin bundle toward the pads
  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oe;
  } bpc_pad_t;
endpackage : bpc_pkg

//--- hw/bpc_pin_cell.sv
// one port pin: direction decode onto the pad driver
`timescale 1ns/10ps
`default_nettype none
module bpc_pin_cell (
  input  wire logic latchBit,
  input  wire logic dirBit,
  output logic      padOut,
  output logic      padOe
);
  // a set direction bit floats the driver
  assign padOe  = ~dirBit;
  assign padOut = latchBit;
endmodule : bpc_pin_cell
`default_nettype wire

//--- hw/bpc_sampler.sv
// pin sampler: holds pad levels taken at the start of each cycle
`timescale 1ns/10ps
`default_nettype none
module bpc_sampler #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] padIn,
  output logic      [WIDTH-1:0] sampled
);
  // reads see the level one edge old, so a just-written pin may read stale
  always_ff @(posedge clk) begin
    sampled <= padIn;
  end
endmodule : bpc_sampler
`default_nettype wire

//--- hw/bpc_port.sv
// top of the bidirectional port: axi4-lite slave, latch, direction, pad drive
`timescale 1ns/10ps
`default_nettype none
// Function
// - eight-bit output latch plus one direction bit per pin
// - direction bit one puts that pin's driver in high impedance
// - direction bit zero drives the pin from its latch bit
// - data reads return sampled pin levels; writes update only the latch
// - data writes with s_axi_wstrb[0] set read pins, then replace the whole latch with the written byte
// - data at index 07h, direction at 87h resetting to ones; latch kept
// - a write reaches the latch at the end of its cycle
// - pins are sampled at the start of a read cycle
// - a read right after a write may see the old pin level
module bpc_port #(
  parameter int WIDTH = bpc_pkg::DATA_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [WIDTH-1:0] padIn,
  output logic [WIDTH-1:0]      padOut,
  output logic [WIDTH-1:0]      padOe
);
  typedef struct packed {
    logic             awTaken;
    logic [11:0]      awAddr;
    logic             wTaken;
    logic [WIDTH-1:0] wData;
    logic             wLane;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] direction;
    logic [WIDTH-1:0] padOut;
    logic [WIDTH-1:0] padOe;
  } bpc_state_t;

  bpc_state_t       st;
  bpc_state_t       next_st;
  logic [WIDTH-1:0] sampled;
  logic [WIDTH-1:0] cellOut;
  logic [WIDTH-1:0] cellOe;
  logic             doWrite;

  // pad levels captured at the start of every cycle
  bpc_sampler #(.WIDTH(WIDTH)) u_sampler (
    .clk     (clk),
    .padIn   (padIn),
    .sampled (sampled)
  );

  // one independent cell per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gPin
      bpc_pin_cell u_cell (
        .latchBit (st.latch[g]),
        .dirBit   (st.direction[g]),
        .padOut   (cellOut[g]),
        .padOe    (cellOe[g])
      );
    end
  endgenerate

  assign doWrite = st.awTaken & st.wTaken & ~st.bValid;

  // next-state: bus handshakes, register updates, pad registering
  always_comb begin
    next_st = st;
    next_st.padOut = cellOut; // registered so pads come from flops
    next_st.padOe  = cellOe;
    if (s_axi_awvalid && !st.awTaken) begin
      next_st.awTaken = 1'b1;
      next_st.awAddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wTaken) begin
      next_st.wTaken = 1'b1;
      next_st.wData  = s_axi_wdata[WIDTH-1:0];
      next_st.wLane  = s_axi_wstrb[0];
    end
    // commit once both halves are in; latch changes at end of this cycle
    if (doWrite) begin
      next_st.bValid = 1'b1;
      next_st.bResp  = bpc_pkg::RESP_OKAY;
      unique case (st.awAddr)
        bpc_pkg::ADDR_DATA: begin
          // pins read first, then replaced: bytewide write keeps no pin bits
          if (st.wLane) begin
            next_st.latch = sampled;
            next_st.latch = st.wData;
          end
        end
        bpc_pkg::ADDR_DIRECTION: begin
          if (st.wLane) begin
            next_st.direction = st.wData;
          end
        end
        default: next_st.bResp = bpc_pkg::RESP_SLVERR;
      endcase
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid  = 1'b0;
      next_st.awTaken = 1'b0;
      next_st.wTaken  = 1'b0;
    end
    // reads: data shows pins, never the latch
    if (s_axi_arvalid && !st.rValid) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = bpc_pkg::RESP_OKAY;
      next_st.rData  = 32'h0000_0000;
      unique case (s_axi_araddr)
        bpc_pkg::ADDR_DATA:      next_st.rData[WIDTH-1:0] = sampled;
        bpc_pkg::ADDR_DIRECTION: next_st.rData[WIDTH-1:0] = st.direction;
        default:                 next_st.rResp = bpc_pkg::RESP_SLVERR;
      endcase
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    // every reset forces inputs; the data latch is left alone
    if (!rst_n) begin
      next_st.awTaken   = 1'b0;
      next_st.wTaken    = 1'b0;
      next_st.bValid    = 1'b0;
      next_st.rValid    = 1'b0;
      next_st.direction = bpc_pkg::DIR_RESET;
      next_st.padOe     = '0;
    end
  end

  // the latch has no reset: it stays unknown until software first writes it
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign s_axi_awready = ~st.awTaken;
  assign s_axi_wready  = ~st.wTaken;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = ~st.rValid;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
  assign padOut        = st.padOut;
  assign padOe         = st.padOe;
endmodule : bpc_port
`default_nettype wire

//--- test/bpc_port_asserts.sv
// checker for the bidirectional port: handshakes and pad updates
`timescale 1ns/10ps
`default_nettype none
module bpc_port_check #(
  parameter int WIDTH = 8
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [WIDTH-1:0] padOut,
  input wire logic [WIDTH-1:0] padOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // both halves of a write accepted
  sequence s_wr_taken;
    !s_axi_awready && !s_axi_wready;
  endsequence
  a_oe_reset: assert property ($rose(rst_n) |-> padOe == '0)
    else $error("pads driven after reset");
  a_resp_cause: assert property ($rose(s_axi_bvalid) |-> s_wr_taken)
    else $error("response before both halves");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_rresp_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address accepted twice");
  a_oe_write: assert property ($changed(padOe) |-> $past(s_axi_bvalid))
    else $error("drive changed without write");
  a_out_write: assert property ($changed(padOut) |-> $past(s_axi_bvalid))
    else $error("latch changed without write");
endmodule : bpc_port_check
bind bpc_port bpc_port_check #(.WIDTH(WIDTH)) i_chk (.*);
`default_nettype wire

//--- test/bpc_pin_model.sv
// model of the circuitry on the port pins
`timescale 1ns/10ps
`default_nettype none
module bpc_pin_model (
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] padIn
);
  // released pins follow the outside source, driven ones the port
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule : bpc_pin_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the bidirectional port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'h0, rst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  padIn, padOut, padOe, extLevel = 8'h3c;
  int          n_mismatch = 0, comparisons = 0;
  // free-running clock
  always #5 clk = ~clk;
  bpc_port i_dut (.*);
  bpc_pin_model i_pins (.padOut, .padOe, .extLevel, .padIn);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    {rdat, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask : rdr
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop;
  end
  // test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rdr(bpc_pkg::ADDR_DIRECTION);
    chk(rdat, 32'hff);
    chk(padOe, 8'h00);
    $display("reset test done");
    wr(bpc_pkg::ADDR_DATA, 32'ha5);
    chk(rsp, bpc_pkg::RESP_OKAY);
    wr(bpc_pkg::ADDR_DIRECTION, 32'h0f);
    repeat (2) @(posedge clk);
    chk(padOe, 8'hf0);
    chk(padOut, 8'ha5);
    rdr(bpc_pkg::ADDR_DATA);
    chk(rdat, 32'hac);
    wr(bpc_pkg::ADDR_DATA, 32'h5a);
    rdr(bpc_pkg::ADDR_DATA);
    chk(rdat == 32'hac || rdat == 32'h5c, 32'h1);
    rdr(bpc_pkg::ADDR_DATA);
    chk(rdat, 32'h5c);
    s_axi_wstrb <= 4'h0;
    wr(bpc_pkg::ADDR_DATA, 32'hff);
    s_axi_wstrb <= 4'hf;
    repeat (2) @(posedge clk);
    chk(padOut, 8'h5a);
    wr(bpc_pkg::ADDR_DIRECTION, 32'h0e);
    repeat (2) @(posedge clk);
    chk(padOe, 8'hf1);
    $display("pin test done");
    wr(12'h004, 32'h00);
    chk(rsp, bpc_pkg::RESP_SLVERR);
    rdr(12'h004);
    chk(rsp, bpc_pkg::RESP_SLVERR);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rdr(bpc_pkg::ADDR_DIRECTION);
    chk(rdat, 32'hff);
    chk(padOut, 8'h5a);
    chk(padOe, 8'h00);
    $display("map and reset test done");
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
